// File: core/tws_cfg.svh
/*
  Constants of the two-wire slave port: slave address code, block range,
  clock figures and the internal write cycle time.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define TWS_CTRL_CODE 4'hD
`define TWS_BLK_LAST 2'h2
`define TWS_BLK_RTC 2'h0
`define TWS_REF_NS 10
`define TWS_EE_WR_US 10000
`define TWS_STD_KHZ 100
`define TWS_FAST_KHZ 400
`define TWS_MEM_WORDS 768
`endif

// File: core/tws_pkg.sv
/*
  Types of the two-wire slave port: bus states, the request word that
  crosses from the link domain to the core domain, and the pin pair.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tws_pkg;
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK, ST_WDATA, ST_WDATA_ACK,
    ST_RDATA, ST_RACK} tws_state_t;
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [7:0] data;
  } tws_req_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_t;
endpackage

// File: core/tws_slave.sv
/*
  Two-wire slave port with three 256-byte blocks (block 0 clock registers,
  blocks 1 and 2 EEPROM) and a timed EEPROM write cycle.
  Assumes an external master drives SCL and the open-drain SDA wire is
  resolved outside; LINK_CLK free-running and well above 4x the bus rate.
*/
`timescale 1ns/10ps
`include "tws_cfg.svh"
module tws_slave #(
  parameter int WR_CYCLES = `TWS_EE_WR_US * 1000 / `TWS_REF_NS
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire tws_pkg::tws_pins_t PINS_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic EE_BUSY
);
  import tws_pkg::*;

  // link domain: reset through two flip-flops, pins through three
  logic [1:0] lrst_q;
  tws_pins_t pin_m_q, pin_s_q, pin_p_q;
  always_ff @(posedge LINK_CLK) begin
    lrst_q <= {lrst_q[0], RST};
  end
  wire logic lrst = lrst_q[1];
  always_ff @(posedge LINK_CLK) begin
    pin_m_q <= PINS_IN;
    pin_s_q <= pin_m_q;
    pin_p_q <= pin_s_q;
  end
  // SDA moving while SCL stays high is a condition, never data
  wire logic scl_hi = pin_s_q.scl & pin_p_q.scl;
  wire logic start_c = scl_hi & pin_p_q.sda & ~pin_s_q.sda;
  wire logic stop_c = scl_hi & ~pin_p_q.sda & pin_s_q.sda;
  // sampling at link rate rather than on SCL keeps both bus speeds on one path
  wire logic scl_rise = pin_s_q.scl & ~pin_p_q.scl;
  wire logic scl_fall = ~pin_s_q.scl & pin_p_q.scl;

  // core answers crossing back: busy level and request acknowledge toggle
  logic busy_q, ack_tgl_q;
  logic [7:0] rdata_q;
  logic [1:0] busy_l_q;
  logic [2:0] ack_l_q;
  always_ff @(posedge LINK_CLK) begin
    busy_l_q <= {busy_l_q[0], busy_q};
    ack_l_q <= {ack_l_q[1:0], ack_tgl_q};
  end

  tws_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q, tx_q, rx_q, ptr_q;
  logic [1:0] blk_q;
  logic oe_q, wrote_q, req_tgl_q, cyc_tgl_q, cyc_ee_q;
  tws_req_t req_q;

  // read data is stable once the core toggled its answer
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      rx_q <= 8'h00;
    end else if (ack_l_q[2] != ack_l_q[1]) begin
      rx_q <= rdata_q;
    end
  end

  wire logic addr_ok = shreg_q[7:4] == `TWS_CTRL_CODE && shreg_q[3] == 1'b0
    && shreg_q[2:1] <= `TWS_BLK_LAST;
  // block 0 stays served during programming, so a master can keep polling it
  wire logic ee_blocked = busy_l_q[1] && shreg_q[2:1] != `TWS_BLK_RTC;
  // acks and read bits move only after SCL falls, never under SCL high
  wire logic byte_end = scl_fall && cnt_q == 4'h8;

  // shift register: sample on SCL high, most significant bit first
  always_ff @(posedge LINK_CLK) begin
    if (lrst || start_c) begin
      shreg_q <= 8'h00;
    end else if (scl_rise) begin
      shreg_q <= {shreg_q[6:0], pin_s_q.sda};
    end
  end

  // bus state machine; slave only, SCL never driven
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (start_c) begin
      state_q <= ST_ADDR;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      if (scl_rise && cnt_q != 4'h8) begin
        cnt_q <= cnt_q + 4'h1;
      end
      case (state_q)
        ST_ADDR: begin
          if (byte_end) begin
            if (addr_ok && !ee_blocked) begin
              state_q <= ST_ADDR_ACK;
              oe_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_WORD, ST_WDATA: begin
          if (byte_end) begin
            state_q <= state_q == ST_WORD ? ST_WORD_ACK : ST_WDATA_ACK;
            oe_q <= 1'b1;
          end
        end
        ST_ADDR_ACK, ST_WORD_ACK, ST_WDATA_ACK: begin
          // low held until SCL falls after the ninth pulse
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (state_q == ST_ADDR_ACK && tx_q[0]) begin
              state_q <= ST_RDATA;
              oe_q <= ~rx_q[7];
            end else begin
              state_q <= state_q == ST_ADDR_ACK ? ST_WORD : ST_WDATA;
              oe_q <= 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (byte_end) begin
            state_q <= ST_RACK;
            oe_q <= 1'b0;
          end else if (scl_fall) begin
            oe_q <= ~tx_q[7 - cnt_q[2:0]];
          end
        end
        ST_RACK: begin
          if (scl_rise && pin_s_q.sda) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            state_q <= ST_RDATA;
            cnt_q <= 4'h0;
            oe_q <= ~rx_q[7];
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // transmit byte, direction bit, block and pointer
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      tx_q <= 8'h00;
      blk_q <= 2'h0;
      ptr_q <= 8'h00;
    end else if (state_q == ST_ADDR && byte_end && addr_ok && !ee_blocked) begin
      blk_q <= shreg_q[2:1];
      tx_q <= {7'h00, shreg_q[0]};
    end else if (state_q == ST_WORD && byte_end) begin
      ptr_q <= shreg_q;
    end else if (state_q == ST_WDATA && byte_end) begin
      ptr_q <= ptr_q + 8'h01;
    end else if (state_q == ST_RDATA && byte_end) begin
      ptr_q <= ptr_q + 8'h01;
    end else if ((state_q == ST_ADDR_ACK || state_q == ST_RACK) && scl_fall
      && !(state_q == ST_ADDR_ACK && !tx_q[0])) begin
      tx_q <= rx_q;
    end
  end

  // requests to the core, one toggle per written or read data byte and per read address; word stays until next toggle
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
      wrote_q <= 1'b0;
      cyc_tgl_q <= 1'b0;
      cyc_ee_q <= 1'b0;
    end else if (stop_c || start_c) begin
      wrote_q <= 1'b0;
      if (stop_c && wrote_q) begin
        cyc_tgl_q <= ~cyc_tgl_q;
        cyc_ee_q <= blk_q != `TWS_BLK_RTC;
      end
    end else if (state_q == ST_WDATA && byte_end) begin
      req_q <= '{we: 1'b1, addr: {blk_q, ptr_q}, data: shreg_q};
      req_tgl_q <= ~req_tgl_q;
      wrote_q <= 1'b1;
    end else if (state_q == ST_ADDR && byte_end && addr_ok && !ee_blocked && shreg_q[0]) begin
      req_q <= '{we: 1'b0, addr: {shreg_q[2:1], ptr_q}, data: 8'h00};
      req_tgl_q <= ~req_tgl_q;
    end else if (state_q == ST_RDATA && byte_end) begin
      // fetch ahead so the next byte is ready before the ack pulse ends
      req_q <= '{we: 1'b0, addr: {blk_q, ptr_q + 8'h01}, data: 8'h00};
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // open drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;

  // core domain
  logic [2:0] req_c_q, cyc_c_q;
  logic [31:0] tmr_q;
  logic [7:0] mem [`TWS_MEM_WORDS];
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      req_c_q <= 3'h0;
      cyc_c_q <= 3'h0;
    end else begin
      req_c_q <= {req_c_q[1:0], req_tgl_q};
      cyc_c_q <= {cyc_c_q[1:0], cyc_tgl_q};
    end
  end
  wire logic req_ev = req_c_q[2] != req_c_q[1];
  wire logic cyc_ev = cyc_c_q[2] != cyc_c_q[1];

  // memory has no reset; contents are nonvolatile by intent
  always_ff @(posedge REF_CLK) begin
    if (req_ev && req_q.we) begin
      mem[req_q.addr] <= req_q.data;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (req_ev) begin
      if (!req_q.we) begin
        rdata_q <= mem[req_q.addr];
      end
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // write cycle timer; block 0 stays reachable while it runs
  // 32 bits cover the longest write time at the core clock with margin
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_q <= 1'b0;
      tmr_q <= 32'h0;
    end else if (cyc_ev && cyc_ee_q) begin
      busy_q <= 1'b1;
      tmr_q <= 32'(WR_CYCLES);
    end else if (busy_q) begin
      tmr_q <= tmr_q - 32'h1;
      busy_q <= tmr_q > 32'h1;
    end
  end
  assign EE_BUSY = busy_q;

  // link-domain checks, with the REF_CLK ones among them guarding the write cycle timer
  property p_start;
    @(posedge LINK_CLK) disable iff (lrst) start_c |=> state_q == ST_ADDR && cnt_q == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    @(posedge LINK_CLK) disable iff (lrst) stop_c && !start_c |=> state_q == ST_IDLE && !oe_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_nomatch;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_ADDR && byte_end && shreg_q[7:4] != `TWS_CTRL_CODE && !start_c && !stop_c
      |=> !oe_q && state_q == ST_IDLE;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign address acknowledged");
  property p_busy;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_ADDR && byte_end && busy_l_q[1] && shreg_q[2:1] != 2'h0 && !start_c && !stop_c |=> !oe_q;
  endproperty
  a_busy: assert property (p_busy) else $error("ack during write cycle");
  property p_ackhold;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_WORD_ACK && scl_rise |-> oe_q [*4];
  endproperty
  a_ackhold: assert property (p_ackhold) else $error("ack released in high phase");
  property p_word;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_WORD && byte_end && !start_c && !stop_c |=> ptr_q == $past(shreg_q) && oe_q;
  endproperty
  a_word: assert property (p_word) else $error("word address not loaded");
  property p_inc;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_WDATA && byte_end && !start_c && !stop_c |=> ptr_q == $past(ptr_q) + 8'h01 && oe_q;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer not advanced");
  property p_wrap;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_RDATA && byte_end && ptr_q == 8'hFF && !start_c && !stop_c |=> ptr_q == 8'h00 && $stable(blk_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("read pointer left block");
  property p_cyc;
    @(posedge LINK_CLK) disable iff (lrst) stop_c && wrote_q |=> cyc_tgl_q != $past(cyc_tgl_q);
  endproperty
  a_cyc: assert property (p_cyc) else $error("write cycle not started");
  property p_nack;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_RACK && scl_rise && pin_s_q.sda && !stop_c && !start_c |=> !oe_q ##1 !oe_q;
  endproperty
  a_nack: assert property (p_nack) else $error("sda held after nack");
  property p_busy_len;
    @(posedge REF_CLK) disable iff (RST) $rose(busy_q) |-> tmr_q != 32'h0;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle without time");
  property p_addr_ack;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_ADDR && byte_end && shreg_q[7:4] == `TWS_CTRL_CODE && shreg_q[3:1] == 3'h0
      && !start_c && !stop_c |=> oe_q && state_q == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
  property p_rd_first;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_ADDR_ACK && scl_fall && tx_q[0] && !start_c && !stop_c
      |=> state_q == ST_RDATA && oe_q == ~$past(rx_q[7]);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first read bit wrong");
  property p_ack_release;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_WDATA_ACK && scl_fall && !start_c && !stop_c |=> !oe_q && state_q == ST_WDATA;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held past ninth pulse");
  property p_rd_release;
    @(posedge LINK_CLK) disable iff (lrst)
      state_q == ST_RDATA && byte_end && !start_c && !stop_c |=> !oe_q && state_q == ST_RACK;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("sda held in master ack slot");
  property p_idle_quiet;
    @(posedge LINK_CLK) disable iff (lrst) state_q == ST_IDLE |=> !oe_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda pulled while idle");
  property p_stop_clear;
    @(posedge LINK_CLK) disable iff (lrst) stop_c |=> !wrote_q;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("write mark kept after stop");
  property p_ee_start;
    @(posedge REF_CLK) disable iff (RST) cyc_ev && cyc_ee_q |=> busy_q && tmr_q == WR_CYCLES;
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("eeprom cycle not loaded");
  property p_busy_run;
    @(posedge REF_CLK) disable iff (RST) busy_q && tmr_q > 32'h1 |=> busy_q;
  endproperty
  a_busy_run: assert property (p_busy_run) else $error("write cycle cut short");

  c_write: cover property (@(posedge LINK_CLK) disable iff (lrst) state_q == ST_WDATA_ACK && scl_fall);
  c_read: cover property (@(posedge LINK_CLK) disable iff (lrst) state_q == ST_RACK && scl_fall);
  c_busy: cover property (@(posedge LINK_CLK) disable iff (lrst) state_q == ST_ADDR && byte_end && ee_blocked);
  c_rstart: cover property (@(posedge LINK_CLK) disable iff (lrst) state_q == ST_WDATA && start_c);
  c_nomatch: cover property (@(posedge LINK_CLK) disable iff (lrst) state_q == ST_ADDR && byte_end && !addr_ok);
endmodule

// File: tb/tws_master_model.sv
/*
  Behavioural two-wire bus master: drives SCL and its side of the SDA wire.
  Assumes SDA has a pull-up; the slave puts sda_out on the wire while sda_oe is high.
*/
`timescale 1ns/10ps
module tws_master_model #(
  parameter int QTR = 63
) (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output tws_pkg::tws_pins_t pins
);
  import tws_pkg::*;
  logic scl_q = 1'h1;
  logic sda_q = 1'h1;
  // wired-and with pull-up: a released line reads high
  assign pins = '{scl: scl_q, sda: sda_q & (sda_oe ? sda_out : 1'h1)};
  // 63 cycles a quarter keeps the bit period just under 400 kHz
  task automatic qwait();
    repeat (QTR) @(posedge clk);
  endtask
  task automatic start_cond();
    sda_q <= 1'h1;
    qwait();
    scl_q <= 1'h1;
    qwait();
    sda_q <= 1'h0;
    qwait();
    scl_q <= 1'h0;
    qwait();
  endtask
  task automatic stop_cond();
    sda_q <= 1'h0;
    qwait();
    scl_q <= 1'h1;
    qwait();
    sda_q <= 1'h1;
    qwait();
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    sda_q <= b;
    qwait();
    scl_q <= 1'h1;
    qwait();
    r = pins.sda;
    qwait();
    scl_q <= 1'h0;
    qwait();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'h1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask
endmodule

// File: tb/i2c_slave_address_write_port_test.sv
/*
  Self-checking bench of the two-wire slave port, random data, fixed seed.
  Assumes tws_master_model as the bus master and a pull-up on SDA.
*/
`timescale 1ns/10ps
module i2c_slave_address_write_port_test;
  import tws_pkg::*;
  localparam int WR = 6000;
  logic ref_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic sda_oe;
  logic sda_out;
  logic ee_busy;
  tws_pins_t pins;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int busy_len = 0;
  int last_busy = 0;
  integer seed = 32'h35888e79;
  logic ack;
  logic [7:0] w, d0, d1, g0, g1;
  logic [7:0] bad [3];
  always #5 ref_clk = ~ref_clk;
  initial begin
    #7 link_clk = 1'h1;
    forever #16 link_clk = ~link_clk;
  end
  tws_slave #(.WR_CYCLES(WR)) dut_u (.REF_CLK(ref_clk), .RST(rst), .LINK_CLK(link_clk), .PINS_IN(pins),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .EE_BUSY(ee_busy));
  tws_master_model mst_u (.clk(ref_clk), .sda_oe(sda_oe), .sda_out(sda_out), .pins(pins));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    busy_len <= ee_busy ? busy_len + 1 : 0;
    if (!ee_busy && busy_len != 0) last_busy <= busy_len;
    if (cycles == 90000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] addr_of(input logic [1:0] blk, input logic rd);
    return {4'hD, 1'h0, blk, rd};
  endfunction
  function automatic logic exp_ack(input logic [7:0] a, input logic busy);
    return a[7:4] == 4'hD && !a[3] && a[2:1] != 2'h3 && !(busy && a[2:1] != 2'h0);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_chk(input logic [7:0] b, input logic exp);
    mst_u.send_byte(b, ack);
    chk({7'h0, ack}, {7'h0, exp});
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (20) @(posedge ref_clk);
    w = 8'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    mst_u.start_cond();
    wr_chk(addr_of(2'h1, 1'h0), 1'h1);
    wr_chk(w, 1'h1);
    wr_chk(d0, 1'h1);
    wr_chk(d1, 1'h1);
    mst_u.stop_cond();
    repeat (20) @(posedge ref_clk);
    chk({7'h0, ee_busy}, 8'h01);
    $display("test eeprom_write done");
    mst_u.start_cond();
    wr_chk(addr_of(2'h1, 1'h0), exp_ack(addr_of(2'h1, 1'h0), 1'h1));
    mst_u.start_cond();
    wr_chk(addr_of(2'h0, 1'h0), exp_ack(addr_of(2'h0, 1'h0), 1'h1));
    mst_u.stop_cond();
    for (int i = 0; i < 8000 && ee_busy !== 1'h0; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    chk(8'(last_busy >= WR - 1 && last_busy <= WR + 1), 8'h01);
    $display("test ack_polling done");
    mst_u.start_cond();
    wr_chk(addr_of(2'h1, 1'h0), 1'h1);
    wr_chk(w, 1'h1);
    mst_u.start_cond();
    wr_chk(addr_of(2'h1, 1'h1), 1'h1);
    mst_u.recv_byte(1'h1, g0);
    mst_u.recv_byte(1'h0, g1);
    repeat (30) @(posedge ref_clk);
    chk({7'h0, sda_oe}, 8'h00);
    mst_u.stop_cond();
    chk(g0, d0);
    chk(g1, d1);
    $display("test random_read done");
    mst_u.start_cond();
    wr_chk(addr_of(2'h0, 1'h0), 1'h1);
    wr_chk(8'hFF, 1'h1);
    wr_chk(d1, 1'h1);
    wr_chk(d0, 1'h1);
    mst_u.stop_cond();
    repeat (20) @(posedge ref_clk);
    chk({7'h0, ee_busy}, 8'h00);
    mst_u.start_cond();
    wr_chk(addr_of(2'h0, 1'h0), 1'h1);
    wr_chk(8'hFF, 1'h1);
    mst_u.start_cond();
    wr_chk(addr_of(2'h0, 1'h1), 1'h1);
    mst_u.recv_byte(1'h1, g0);
    mst_u.recv_byte(1'h0, g1);
    mst_u.stop_cond();
    chk(g0, d1);
    chk(g1, d0);
    $display("test block_wrap done");
    bad[0] = 8'($random(seed));
    if (bad[0][7:4] == 4'hD) bad[0][7:4] = 4'h5;
    bad[1] = 8'hD8;
    bad[2] = 8'hD6;
    for (int k = 0; k < 3; k++) begin
      mst_u.start_cond();
      wr_chk(bad[k], exp_ack(bad[k], 1'h0));
      // a valid-looking address as data must still be ignored
      wr_chk(addr_of(2'h1, 1'h0), 1'h0);
      mst_u.stop_cond();
    end
    $display("test foreign_address done");
    tally_and_finish();
  end
endmodule
